// ---- common/ssf_pkg.sv ----
// Package for the status-flag and interrupt-source logic
package ssf_pkg;
    localparam int SSF_AW = 8;
    localparam int SSF_DW = 8;
    // Register offsets
    localparam logic [7:0] SSF_A_EVENT = 8'h0b;
    localparam logic [7:0] SSF_A_BUFCTL = 8'h28;
    localparam logic [7:0] SSF_A_WMARK = 8'h29;
    localparam logic [7:0] SSF_A_ROUTE1 = 8'h2a;
    localparam logic [7:0] SSF_A_ROUTE2 = 8'h2b;
    localparam logic [7:0] SSF_A_SELF = 8'h2e;
    // Sample register ranges
    localparam logic [7:0] SSF_A_SMP_LO0 = 8'h08;
    localparam logic [7:0] SSF_A_SMP_HI0 = 8'h0a;
    localparam logic [7:0] SSF_A_SMP_LO1 = 8'h0e;
    localparam logic [7:0] SSF_A_SMP_HI1 = 8'h15;
    // Event bit positions, shared by flag and route registers, and the route-only polarity bit
    localparam int SSF_B_NEWSMP = 0;
    localparam int SSF_B_BUFRDY = 1;
    localparam int SSF_B_WMARK = 2;
    localparam int SSF_B_OVRUN = 3;
    localparam int SSF_B_MOTION = 4;
    localparam int SSF_B_STILL = 5;
    localparam int SSF_B_ACTLOW = 7;
    localparam int SSF_NEVT = 6;
    // Buffer control and self check fields
    localparam int SSF_B_THRHI = 3;
    localparam int SSF_B_MODE_LO = 0;
    localparam int SSF_B_SELFCHK = 0;
    // Reset values
    localparam logic [7:0] SSF_RST_WMARK = 8'h80;
    localparam logic [7:0] SSF_RST_ZERO = 8'h00;
    // Buffer modes
    typedef enum logic [1:0] {
        SSF_MODE_OFF = 2'b00,
        SSF_MODE_OLDEST = 2'b01,
        SSF_MODE_STREAM = 2'b10,
        SSF_MODE_TRIG = 2'b11
    } ssf_mode_t;
endpackage : ssf_pkg

// ---- design/ssf_flags.sv ----
// Status flags, interrupt routing and self check control
`timescale 1ns/10ps
module ssf_flags #(
    parameter int CNT_W = 10
) (
    // Clock and reset
    input logic mclk,
    input logic srst,
    // Decoded register port from the serial interface
    input logic [ssf_pkg::SSF_AW-1:0] reg_addr,
    input logic reg_wr,
    input logic [ssf_pkg::SSF_DW-1:0] reg_wdata,
    input logic reg_rd_begin,
    input logic reg_rd_finish,
    output logic [ssf_pkg::SSF_DW-1:0] reg_rdata,
    // Motion detector
    input logic motion_evt,
    input logic stillness_evt,
    // Sample path
    input logic sample_new,
    // Sample buffer
    input logic [CNT_W-1:0] buf_count,
    input logic buf_out_valid,
    input logic buf_push,
    input logic buf_full,
    input logic buf_pop,
    output logic [1:0] buf_mode,
    // Self check
    output logic self_check_drive,
    // Interrupt pins
    output logic irq_pin_one,
    output logic irq_pin_one_oe_n,
    output logic irq_pin_two,
    output logic irq_pin_two_oe_n
);
    import ssf_pkg::*;

    function automatic logic is_sample_addr(input logic [SSF_AW-1:0] a);
        is_sample_addr = ((a >= SSF_A_SMP_LO0) && (a <= SSF_A_SMP_HI0)) ||
                         ((a >= SSF_A_SMP_LO1) && (a <= SSF_A_SMP_HI1));
    endfunction : is_sample_addr

    function automatic logic wr_hit(input logic [SSF_AW-1:0] a,
                                    input logic [SSF_AW-1:0] target,
                                    input logic we);
        wr_hit = we && (a == target);
    endfunction : wr_hit

    // Configuration registers
    logic [SSF_DW-1:0] bufctl_r;
    logic [SSF_DW-1:0] wmark_r;
    logic [SSF_DW-1:0] route1_r;
    logic [SSF_DW-1:0] route2_r;
    logic [SSF_DW-1:0] self_r;

    // Flags
    logic motion_flag_r;
    logic stillness_flag_r;
    logic newsmp_r;
    logic newsmp_nxt;
    logic wmark_flag_r;
    logic bufrdy_r;
    logic ovrun_r;
    logic ovrun_nxt;

    // Sample read tracking
    logic in_read_r;
    logic pend_r;
    logic smp_rd_begin;
    logic evt_rd_begin;

    // Threshold and mode
    logic [CNT_W-1:0] threshold;
    logic thr_hi;
    logic buf_off;
    logic [SSF_NEVT-1:0] events;
    logic [SSF_DW-1:0] flag_byte;

    assign smp_rd_begin = reg_rd_begin && is_sample_addr(reg_addr);
    assign evt_rd_begin = reg_rd_begin && (reg_addr == SSF_A_EVENT);
    assign buf_mode = bufctl_r[SSF_B_MODE_LO +: 2];
    assign buf_off = (buf_mode == SSF_MODE_OFF);
    assign thr_hi = bufctl_r[SSF_B_THRHI];
    assign threshold = CNT_W'({thr_hi, wmark_r});
    assign self_check_drive = self_r[SSF_B_SELFCHK];

    // Buffer control register
    always_ff @(posedge mclk) begin
        if (srst) begin
            bufctl_r <= SSF_RST_ZERO;
        end else if (wr_hit(reg_addr, SSF_A_BUFCTL, reg_wr)) begin
            bufctl_r <= reg_wdata;
        end
    end

    // Watermark threshold register; the large reset value keeps it quiet
    always_ff @(posedge mclk) begin
        if (srst) begin
            wmark_r <= SSF_RST_WMARK;
        end else if (wr_hit(reg_addr, SSF_A_WMARK, reg_wr)) begin
            wmark_r <= reg_wdata;
        end
    end

    // Route registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            route1_r <= SSF_RST_ZERO;
        end else if (wr_hit(reg_addr, SSF_A_ROUTE1, reg_wr)) begin
            route1_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            route2_r <= SSF_RST_ZERO;
        end else if (wr_hit(reg_addr, SSF_A_ROUTE2, reg_wr)) begin
            route2_r <= reg_wdata;
        end
    end

    // Self check enable
    always_ff @(posedge mclk) begin
        if (srst) begin
            self_r <= SSF_RST_ZERO;
        end else if (wr_hit(reg_addr, SSF_A_SELF, reg_wr)) begin
            self_r <= reg_wdata;
        end
    end

    // Motion and stillness: event wins over the read clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            motion_flag_r <= 1'b0;
        end else if (motion_evt) begin
            motion_flag_r <= 1'b1;
        end else if (evt_rd_begin) begin
            motion_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stillness_flag_r <= 1'b0;
        end else if (stillness_evt) begin
            stillness_flag_r <= 1'b1;
        end else if (evt_rd_begin) begin
            stillness_flag_r <= 1'b0;
        end
    end

    // Sample read window, from begin to finish
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_read_r <= 1'b0;
        end else if (smp_rd_begin) begin
            in_read_r <= 1'b1;
        end else if (reg_rd_finish) begin
            in_read_r <= 1'b0;
        end
    end

    // Samples arriving during a read wait here until it ends
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_r <= 1'b0;
        end else if (in_read_r && reg_rd_finish) begin
            pend_r <= 1'b0;
        end else if (sample_new && (in_read_r || smp_rd_begin)) begin
            pend_r <= 1'b1;
        end
    end

    // New-sample flag next value
    always_comb begin
        newsmp_nxt = newsmp_r;
        if (smp_rd_begin) begin
            newsmp_nxt = 1'b0;
        end else if (in_read_r) begin
            if (reg_rd_finish) begin
                newsmp_nxt = pend_r || sample_new;
            end else begin
                newsmp_nxt = 1'b0;
            end
        end else if (sample_new) begin
            newsmp_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            newsmp_r <= 1'b0;
        end else begin
            newsmp_r <= newsmp_nxt;
        end
    end

    // Watermark follows the live count, so reads clear it on their own
    always_ff @(posedge mclk) begin
        if (srst) begin
            wmark_flag_r <= 1'b0;
        end else begin
            wmark_flag_r <= (buf_count >= threshold);
        end
    end

    // Buffer-ready condition
    always_ff @(posedge mclk) begin
        if (srst) begin
            bufrdy_r <= 1'b0;
        end else begin
            bufrdy_r <= buf_out_valid;
        end
    end

    // Overrun: a full buffer loses a sample in every active mode.
    // Stream and triggered lose the oldest, oldest-saved loses the new one.
    always_comb begin
        ovrun_nxt = ovrun_r;
        if (buf_off) begin
            ovrun_nxt = 1'b0;
        end else if (buf_push && buf_full) begin
            ovrun_nxt = 1'b1;
        end else if (buf_pop) begin
            ovrun_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ovrun_r <= 1'b0;
        end else begin
            ovrun_r <= ovrun_nxt;
        end
    end

    // Event vector in route-bit order
    always_comb begin
        events = '0;
        events[SSF_B_NEWSMP] = newsmp_r;
        events[SSF_B_BUFRDY] = bufrdy_r;
        events[SSF_B_WMARK] = wmark_flag_r;
        events[SSF_B_OVRUN] = ovrun_r;
        events[SSF_B_MOTION] = motion_flag_r;
        events[SSF_B_STILL] = stillness_flag_r;
    end

    assign flag_byte = SSF_DW'(events);

    // Read data captured at read begin, before the read clears anything
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= SSF_RST_ZERO;
        end else if (reg_rd_begin) begin
            unique case (reg_addr)
                SSF_A_EVENT: reg_rdata <= flag_byte;
                SSF_A_BUFCTL: reg_rdata <= bufctl_r;
                SSF_A_WMARK: reg_rdata <= wmark_r;
                SSF_A_ROUTE1: reg_rdata <= route1_r;
                SSF_A_ROUTE2: reg_rdata <= route2_r;
                SSF_A_SELF: reg_rdata <= self_r;
                default: reg_rdata <= SSF_RST_ZERO;
            endcase
        end
    end

    // Pin drivers
    ssf_irq_pin u_pin_one (
        .mclk(mclk),
        .srst(srst),
        .events(events),
        .route(route1_r),
        .pin_out(irq_pin_one),
        .pin_oe_n(irq_pin_one_oe_n)
    );

    ssf_irq_pin u_pin_two (
        .mclk(mclk),
        .srst(srst),
        .events(events),
        .route(route2_r),
        .pin_out(irq_pin_two),
        .pin_oe_n(irq_pin_two_oe_n)
    );
endmodule : ssf_flags

// ---- design/ssf_irq_pin.sv ----
// Interrupt pin driver: mapped OR, polarity and high-Z
`timescale 1ns/10ps
module ssf_irq_pin (
    // Clock and reset
    input logic mclk,
    input logic srst,
    // Event conditions and route register
    input logic [ssf_pkg::SSF_NEVT-1:0] events,
    input logic [ssf_pkg::SSF_DW-1:0] route,
    // Pin
    output logic pin_out,
    output logic pin_oe_n
);
    import ssf_pkg::*;

    logic any_mapped;
    logic hit;

    assign any_mapped = |route[SSF_NEVT-1:0];
    assign hit = |(events & route[SSF_NEVT-1:0]);

    // Registered so the pin never glitches between flag updates
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= hit ^ route[SSF_B_ACTLOW];
        end
    end

    // Unmapped pin and reset leave the pin floating
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= ~any_mapped;
        end
    end
endmodule : ssf_irq_pin

// ---- testbench/ssf_flags_sva.sv ----
// Checker for flag, buffer and pin timing of ssf_flags
`timescale 1ns/10ps
module ssf_flags_sva import ssf_pkg::*; (
    // Clock and reset
    input logic mclk,
    input logic srst,
    // Register port
    input logic [7:0] reg_addr,
    input logic reg_wr,
    input logic [7:0] reg_wdata,
    input logic reg_rd_begin,
    input logic reg_rd_finish,
    input logic [7:0] reg_rdata,
    // Events and buffer
    input logic motion_evt,
    input logic sample_new,
    input logic buf_out_valid,
    input logic buf_push,
    input logic buf_full,
    input logic buf_pop,
    input logic [1:0] buf_mode,
    // Outputs
    input logic self_check_drive,
    input logic irq_pin_one_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_stat;
        reg_rd_begin && reg_addr == SSF_A_EVENT;
    endsequence
    sequence s_smp;
        reg_rd_begin && (reg_addr inside {[8'h08:8'h0a], [8'h0e:8'h15]});
    endsequence
    a_motion_sets_flag: assert property (motion_evt ##1 s_stat |=> reg_rdata[4])
        else $error("motion flag missing");
    a_read_clears_motion: assert property (
        (reg_rd_begin && reg_addr == SSF_A_EVENT && !motion_evt) ##1 (!motion_evt)[*2]
        ##1 s_stat |=> !reg_rdata[4]) else $error("motion flag not cleared");
    a_sample_late_set: assert property (
        s_smp ##1 (sample_new && !reg_rd_finish) ##1 reg_rd_finish ##1 !reg_rd_begin ##1 s_stat
        |=> reg_rdata[0]) else $error("late sample flag missing");
    a_ready_follows: assert property (
        s_stat |=> reg_rdata[1] == $past(buf_out_valid, 2)) else $error("ready flag wrong");
    a_overrun_set: assert property (
        (buf_push && buf_full && buf_mode != SSF_MODE_OFF) ##1 s_stat |=> reg_rdata[3])
        else $error("overrun flag missing");
    a_overrun_off: assert property (
        (buf_mode == SSF_MODE_OFF) ##1 s_stat |=> !reg_rdata[3])
        else $error("overrun kept while disabled");
    a_self_check_follow: assert property (
        reg_wr && reg_addr == SSF_A_SELF |=> self_check_drive == $past(reg_wdata[0]))
        else $error("self check drive wrong");
    a_mode_follow: assert property (
        reg_wr && reg_addr == SSF_A_BUFCTL |=> buf_mode == $past(reg_wdata[1:0]))
        else $error("buffer mode wrong");
    a_pin_high_z: assert property (
        (reg_wr && reg_addr == SSF_A_ROUTE1 && reg_wdata[5:0] == 6'h00)
        ##1 !(reg_wr && reg_addr == SSF_A_ROUTE1) |=> irq_pin_one_oe_n)
        else $error("unrouted pin driven");
endmodule : ssf_flags_sva

bind ssf_flags ssf_flags_sva u_sva (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd_begin(reg_rd_begin),
    .reg_rd_finish(reg_rd_finish), .reg_rdata(reg_rdata), .motion_evt(motion_evt),
    .sample_new(sample_new), .buf_out_valid(buf_out_valid), .buf_push(buf_push),
    .buf_full(buf_full), .buf_pop(buf_pop), .buf_mode(buf_mode),
    .self_check_drive(self_check_drive), .irq_pin_one_oe_n(irq_pin_one_oe_n));

// ---- testbench/ssf_host_model.sv ----
// Host model: register writes, reads and the self check sequence
`timescale 1ns/10ps
module ssf_host_model import ssf_pkg::*; (
    // Clock
    input logic mclk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd_begin,
    output logic reg_rd_finish
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_begin = 1'b0;
        reg_rd_finish = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #2;
        reg_wr = 1'b0;
        // Released lines flip so a stale value never looks valid
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input int n);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_rd_begin = 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(posedge mclk);
            #2;
            reg_rd_begin = 1'b0;
            reg_addr = ~a;
            reg_rd_finish = (i == n);
        end
        @(posedge mclk);
        #2;
        reg_rd_finish = 1'b0;
    endtask : rd
    task automatic self_check(input int period);
        rd(SSF_A_SMP_LO1, 6);
        wr(SSF_A_SELF, 8'h01);
        repeat (period) @(posedge mclk);
        rd(SSF_A_SMP_LO1, 6);
        wr(SSF_A_SELF, 8'h00);
    endtask : self_check
endmodule : ssf_host_model

// ---- testbench/test_ssf_flags.sv ----
// Testbench for ssf_flags with a reference model of the flag rules
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_ssf_flags;
    import ssf_pkg::*;
    logic mclk = 0, srst = 1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd_begin, reg_rd_finish, buf_out_valid = 0, buf_push = 0;
    logic motion_evt = 0, stillness_evt = 0, sample_new = 0, buf_full = 0, buf_pop = 0;
    logic [9:0] buf_count = 0;
    logic [1:0] buf_mode;
    logic self_check_drive, irq_pin_one, irq_pin_one_oe_n, irq_pin_two, irq_pin_two_oe_n;
    int failures = 0, num_checks = 0, cyc = 0;
    logic [7:0] f_r, rt1, rt2, bctl, wm, slf, exp, a;
    logic win, pend, p1, p2, o1, o2, chk, stat, smp;
    logic [7:0] addrs [8] = '{8'h0b, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2e, 8'h00, 8'h3c};
    always #12.5 mclk = ~mclk;
    ssf_flags #(.CNT_W(10)) i_ssf_flags (.mclk, .srst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd_begin, .reg_rd_finish, .reg_rdata, .motion_evt, .stillness_evt,
        .sample_new, .buf_count, .buf_out_valid, .buf_push, .buf_full, .buf_pop, .buf_mode,
        .self_check_drive, .irq_pin_one, .irq_pin_one_oe_n, .irq_pin_two, .irq_pin_two_oe_n);
    ssf_host_model host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd_begin,
        .reg_rd_finish);
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    always @(posedge mclk) begin
        #2;
        if (!srst) begin
            motion_evt = ($urandom % 8) == 0;
            stillness_evt = ($urandom % 8) == 0;
            sample_new = ($urandom % 4) == 0;
            buf_out_valid = $urandom % 2;
            buf_push = $urandom % 2;
            buf_full = $urandom % 2;
            buf_pop = ($urandom % 4) == 0;
            buf_count = 10'($urandom % 600);
        end
    end
    // Cycle ceiling: a hung scenario counts as a mismatch
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            results();
        end
    end
    // Reference model, compared against the design at every edge
    always @(posedge mclk) begin
        if (srst) begin
            {f_r, rt1, rt2, bctl, slf, win, pend, p1, p2, chk} = '0;
            {wm, o1, o2} = {SSF_RST_WMARK, 2'b11};
        end else begin
            if (chk) `CHK("rdata", exp, reg_rdata)
            `CHK("pin1", {p1, o1}, {irq_pin_one, irq_pin_one_oe_n})
            `CHK("pin2", {p2, o2}, {irq_pin_two, irq_pin_two_oe_n})
            `CHK("mode", bctl[1:0], buf_mode)
            `CHK("self", slf[0], self_check_drive)
            stat = reg_rd_begin && reg_addr == SSF_A_EVENT;
            smp = reg_rd_begin && (reg_addr inside {[8'h08:8'h0a], [8'h0e:8'h15]});
            chk = reg_rd_begin && !smp;
            case (reg_addr)
                SSF_A_EVENT: exp = f_r;
                SSF_A_BUFCTL: exp = bctl;
                SSF_A_WMARK: exp = wm;
                SSF_A_ROUTE1: exp = rt1;
                SSF_A_ROUTE2: exp = rt2;
                SSF_A_SELF: exp = slf;
                default: exp = 8'h00;
            endcase
            p1 = (|(f_r[5:0] & rt1[5:0])) ^ rt1[7];
            p2 = (|(f_r[5:0] & rt2[5:0])) ^ rt2[7];
            o1 = rt1[5:0] == 6'h00;
            o2 = rt2[5:0] == 6'h00;
            if (stat) f_r[5:4] = 2'b00;
            f_r[4] |= motion_evt;
            f_r[5] |= stillness_evt;
            if (smp) begin
                {win, f_r[0], pend} = {2'b10, sample_new};
            end else if (win) begin
                pend |= sample_new;
                if (reg_rd_finish) {win, f_r[0]} = {1'b0, pend};
            end else f_r[0] |= sample_new;
            f_r[2] = buf_count >= {1'b0, bctl[3], wm};
            f_r[1] = buf_out_valid;
            if (bctl[1:0] == 2'b00) f_r[3] = 1'b0;
            else if (buf_push && buf_full) f_r[3] = 1'b1;
            else if (buf_pop) f_r[3] = 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    SSF_A_BUFCTL: bctl = reg_wdata;
                    SSF_A_WMARK: wm = reg_wdata;
                    SSF_A_ROUTE1: rt1 = reg_wdata;
                    SSF_A_ROUTE2: rt2 = reg_wdata;
                    SSF_A_SELF: slf = reg_wdata;
                    default: ;
                endcase
            end
        end
    end
    initial begin
        void'($urandom(32'h047dd14a));
        repeat (8) @(posedge mclk);
        #2;
        srst = 0;
        host.rd(SSF_A_WMARK, 1);
        host.wr(SSF_A_WMARK, 8'h00);
        host.rd(SSF_A_EVENT, 1);
        for (int i = 0; i < 1500; i++) begin
            a = addrs[$urandom % 8];
            case ($urandom % 4)
                0: host.wr(a, 8'($urandom) & 8'hbf);
                1: host.rd(a, 1 + $urandom % 2);
                2: host.rd(8'h08 + 8'($urandom % 3), 2);
                default: host.rd(SSF_A_EVENT, 1);
            endcase
        end
        // Unrouted pin one with the polarity bit set must still float; pin two gets the new-sample flag routed
        host.wr(SSF_A_ROUTE1, 8'h80);
        host.wr(SSF_A_ROUTE2, 8'h81);
        // Mid-run reset: registers must come back to their reset values
        @(posedge mclk);
        #2;
        srst = 1;
        repeat (2) @(posedge mclk);
        #2;
        srst = 0;
        host.rd(SSF_A_WMARK, 1);
        host.rd(SSF_A_ROUTE1, 1);
        host.self_check(16);
        results();
    end
endmodule : test_ssf_flags
